//--- rtl/wdt_guard_regs.svh
// Register map, field positions, reset values and timing of the watchdog guard
//
// Overview of operation
// - Period select codes 000..110 divide the slow clock by 2^8,10,12,14,15,16,17.
// - Invalid enable key reset sets flag bit 0; only a software zero clears it.
// - Counter overflow resets the device; software must clear the counter in time.
// - Watchdog runs with key 01010 or 10101; other keys reset after the delay.
// - Enable key starts at 01010 after power-on, so the watchdog runs.
// - Time-out in normal running gives a full reset and sets the time-out flag.
// - Time-out in sleep or idle sets the flag, resets only PC and SP.
// - Counter clears on invalid key write, clear instruction or halt instruction.
// - The single clear instruction alone clears the counter.
// - Power-on reset zeroes the program counter.
// - Power-on reset sets all port data and control registers high.
// - Reset key 01010101 or 10101010 is quiet; other values reset after the delay.
// - Reset key register starts at 01010101 after power-on.
// - Invalid reset key reset sets flag bit 3; only a software zero clears it.
// - Flag register bits 7 to 4 read as zero.
// - The watchdog counts the slow internal oscillator clock, about 32 kHz.
// - Halt sets power-down flag, clears time-out flag, clears counter, keeps counting.
`ifndef WDT_GUARD_REGS_SVH
`define WDT_GUARD_REGS_SVH

`define OFS_WDT_CTRL    8'h00
`define OFS_RST_KEY     8'h04
`define OFS_RST_FLAGS   8'h08
`define OFS_STATUS      8'h0c
`define OFS_COUNT       8'h10

`define WDT_CTRL_POR    8'h53
`define RST_KEY_POR     8'h55
`define WDT_KEY_A       5'h0a
`define WDT_KEY_B       5'h15
`define RST_KEY_A       8'h55
`define RST_KEY_B       8'haa

`define BIT_WDT_KEY_RF  0
`define BIT_RST_KEY_RF  3
`define BIT_TIMEOUT     0
`define BIT_PWR_DOWN    1

`define CLK_PERIOD_NS   10
`define SOFT_RESET_NS   1000
`define SOFT_RESET_CYC  ((`SOFT_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- rtl/wdt_guard_pkg.sv
// Types shared by the watchdog guard
package wdt_guard_pkg;
  typedef enum logic [0:0] {ST_IDLE, ST_WAIT} guard_state_e;
  typedef logic [17:0] wdt_count_t;
endpackage

//--- rtl/sync_2ff.sv
// Two-flop synchroniser with asynchronous reset
`timescale 1ns/1ps
module sync_2ff #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_q;

  // First flop feeds only the second
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= RST_VAL;
      q_o    <= RST_VAL;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule

//--- rtl/wdt_guard.sv
// Watchdog timer with key guards, reset-cause flags and AHB-Lite registers
//
// Implementation choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`include "wdt_guard_regs.svh"
module wdt_guard (
  input  wire logic        CLK_I,
  input  wire logic        RSTN_I,
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic      [31:0] HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  input  wire logic        SLOW_OSC_I,
  input  wire logic        WDT_CLEAR_I,
  input  wire logic        HALT_I,
  input  wire logic        SLEEP_I,
  output logic             CORE_RST_O,
  output logic             PC_SP_RST_O,
  output logic             TIMEOUT_FLAG_O,
  output logic             POWER_DOWN_FLAG_O
);
  localparam logic [15:0] DLY_LAST = 16'(`SOFT_RESET_CYC - 1);
  localparam int DLY_MAX = `SOFT_RESET_CYC + 2;

  logic                       rst_n;
  logic                       osc_s;
  logic                       osc_d_q;
  logic                       tick;
  logic [7:0]                 wdt_ctl_q;
  logic [7:0]                 rst_key_q;
  logic                       wkey_flag_q;
  logic                       rkey_flag_q;
  wdt_guard_pkg::wdt_count_t  cnt_q;
  wdt_guard_pkg::wdt_count_t  lim;
  wdt_guard_pkg::guard_state_e state_q;
  logic [15:0]                dly_q;
  logic                       src_wdt_q;
  logic                       src_rst_q;
  logic                       wdt_key_ok;
  logic                       rst_key_ok;
  logic                       fire;
  logic                       timeout;
  logic                       full_rst;
  logic                       ap_valid;
  logic                       wr_q;
  logic [7:0]                 waddr_q;
  logic                       wr_ctl;
  logic                       wr_key;
  logic                       wr_flags;
  logic                       bad_key_wr;

  // Reset release through two flops
  sync_2ff #(.RST_VAL(1'b0)) u_rst_sync (
    .clk_i   (CLK_I),
    .rst_n_i (RSTN_I),
    .d_i     (1'b1),
    .q_o     (rst_n)
  );

  // Slow oscillator pin is asynchronous to CLK_I
  sync_2ff #(.RST_VAL(1'b0)) u_osc_sync (
    .clk_i   (CLK_I),
    .rst_n_i (rst_n),
    .d_i     (SLOW_OSC_I),
    .q_o     (osc_s)
  );

  // Rising edge of the synchronised slow clock is one count
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      osc_d_q <= 1'b0;
    end else begin
      osc_d_q <= osc_s;
    end
  end
  assign tick = osc_s & ~osc_d_q;

  // Key checks on the stored register values
  assign wdt_key_ok = (wdt_ctl_q[7:3] == `WDT_KEY_A) ||
                      (wdt_ctl_q[7:3] == `WDT_KEY_B);
  assign rst_key_ok = (rst_key_q == `RST_KEY_A) ||
                      (rst_key_q == `RST_KEY_B);

  // Terminal count per period select
  always_comb begin
    case (wdt_ctl_q[2:0])
      3'h0:    lim = 18'h000ff;
      3'h1:    lim = 18'h003ff;
      3'h2:    lim = 18'h00fff;
      3'h3:    lim = 18'h03fff;
      3'h4:    lim = 18'h07fff;
      3'h5:    lim = 18'h0ffff;
      3'h6:    lim = 18'h1ffff;
      default: lim = 18'h3ffff;
    endcase
  end

  assign timeout  = tick & wdt_key_ok & (cnt_q == lim);
  assign full_rst = fire | (timeout & ~SLEEP_I);

  // AHB-Lite decode; zero wait states, writes land in the data phase
  assign ap_valid = HSEL_I & HTRANS_I[1] & HREADY_I;
  assign wr_ctl   = wr_q && (waddr_q == `OFS_WDT_CTRL);
  assign wr_key   = wr_q && (waddr_q == `OFS_RST_KEY);
  assign wr_flags = wr_q && (waddr_q == `OFS_RST_FLAGS);
  assign bad_key_wr = wr_ctl && (HWDATA_I[7:3] != `WDT_KEY_A) &&
                      (HWDATA_I[7:3] != `WDT_KEY_B);

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      wr_q    <= 1'b0;
      waddr_q <= 8'h00;
    end else begin
      wr_q    <= ap_valid & HWRITE_I;
      waddr_q <= HADDR_I[7:0];
    end
  end

  // Read data registered in the address phase, so it stands in the data phase
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      HRDATA_O <= 32'h00000000;
    end else if (ap_valid && !HWRITE_I) begin
      case (HADDR_I[7:0])
        `OFS_WDT_CTRL:  HRDATA_O <= {24'h000000, wdt_ctl_q};
        `OFS_RST_KEY:   HRDATA_O <= {24'h000000, rst_key_q};
        `OFS_RST_FLAGS: HRDATA_O <= {28'h0000000, rkey_flag_q, 2'h0, wkey_flag_q};
        `OFS_STATUS:    HRDATA_O <= {30'h0, POWER_DOWN_FLAG_O, TIMEOUT_FLAG_O};
        `OFS_COUNT:     HRDATA_O <= {14'h0000, cnt_q};
        default:        HRDATA_O <= 32'h00000000;
      endcase
    end else begin
      HRDATA_O <= 32'h00000000;
    end
  end

  // Always ready and OKAY
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end else begin
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end
  end

  // Control register; a full reset restores power-on values so a bad key cannot loop
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      wdt_ctl_q <= `WDT_CTRL_POR;
    end else if (full_rst) begin
      wdt_ctl_q <= `WDT_CTRL_POR;
    end else if (wr_ctl) begin
      wdt_ctl_q <= HWDATA_I[7:0];
    end
  end

  // Reset key register
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      rst_key_q <= `RST_KEY_POR;
    end else if (full_rst) begin
      rst_key_q <= `RST_KEY_POR;
    end else if (wr_key) begin
      rst_key_q <= HWDATA_I[7:0];
    end
  end

  // Watchdog counter; stops while the key is invalid
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 18'h00000;
    end else if (WDT_CLEAR_I || HALT_I || bad_key_wr || timeout || full_rst) begin
      cnt_q <= 18'h00000;
    end else if (tick && wdt_key_ok) begin
      cnt_q <= cnt_q + 18'h00001;
    end
  end

  // Soft-reset delay after a bad key is seen
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= wdt_guard_pkg::ST_IDLE;
      dly_q     <= 16'h0000;
      src_wdt_q <= 1'b0;
      src_rst_q <= 1'b0;
    end else begin
      case (state_q)
        wdt_guard_pkg::ST_IDLE: begin
          dly_q <= 16'h0000;
          if (!wdt_key_ok || !rst_key_ok) begin
            state_q   <= wdt_guard_pkg::ST_WAIT;
            src_wdt_q <= ~wdt_key_ok;
            src_rst_q <= ~rst_key_ok;
          end
        end
        wdt_guard_pkg::ST_WAIT: begin
          if (dly_q == DLY_LAST) begin
            state_q <= wdt_guard_pkg::ST_IDLE;
          end
          dly_q <= dly_q + 16'h0001;
        end
        default: begin
          state_q <= wdt_guard_pkg::ST_IDLE;
        end
      endcase
    end
  end
  assign fire = (state_q == wdt_guard_pkg::ST_WAIT) && (dly_q == DLY_LAST);

  // Reset-cause flags; set beats a software clear in the same cycle
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      wkey_flag_q <= 1'b0;
      rkey_flag_q <= 1'b0;
    end else begin
      if (fire && src_wdt_q) begin
        wkey_flag_q <= 1'b1;
      end else if (wr_flags && !HWDATA_I[`BIT_WDT_KEY_RF]) begin
        wkey_flag_q <= 1'b0;
      end
      if (fire && src_rst_q) begin
        rkey_flag_q <= 1'b1;
      end else if (wr_flags && !HWDATA_I[`BIT_RST_KEY_RF]) begin
        rkey_flag_q <= 1'b0;
      end
    end
  end

  // Status flags; a time-out wins over a clear or halt
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      TIMEOUT_FLAG_O    <= 1'b0;
      POWER_DOWN_FLAG_O <= 1'b0;
    end else begin
      if (timeout) begin
        TIMEOUT_FLAG_O <= 1'b1;
      end else if (HALT_I || WDT_CLEAR_I) begin
        TIMEOUT_FLAG_O <= 1'b0;
      end
      if (HALT_I) begin
        POWER_DOWN_FLAG_O <= 1'b1;
      end else if (WDT_CLEAR_I) begin
        POWER_DOWN_FLAG_O <= 1'b0;
      end
    end
  end

  // Core reset held through power-on, so PC goes to zero and ports come up as inputs
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      CORE_RST_O  <= 1'b1;
      PC_SP_RST_O <= 1'b1;
    end else begin
      CORE_RST_O  <= full_rst;
      PC_SP_RST_O <= full_rst | (timeout & SLEEP_I);
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!rst_n);

  sel_min_a: assert property ((wdt_ctl_q[2:0] == 3'h0 && timeout) |-> cnt_q == 18'h000ff)
    else $error("Shortest period ended at wrong count");
  sel_max_a: assert property ((wdt_ctl_q[2:0] == 3'h7 && timeout) |-> cnt_q == 18'h3ffff)
    else $error("Longest period ended at wrong count");
  wkey_sticky_a: assert property ((wkey_flag_q && !wr_flags) |=> wkey_flag_q)
    else $error("Watchdog key flag dropped without software");
  full_reset_a: assert property ((timeout && !SLEEP_I) |=> CORE_RST_O && TIMEOUT_FLAG_O)
    else $error("Normal time-out gave no full reset");
  key_delay_a: assert property ((state_q == wdt_guard_pkg::ST_IDLE && !wdt_key_ok)
    |-> ##[1:DLY_MAX] (CORE_RST_O && wkey_flag_q))
    else $error("Bad enable key gave no delayed reset");
  rkey_delay_a: assert property ((state_q == wdt_guard_pkg::ST_IDLE && !rst_key_ok)
    |-> ##[1:DLY_MAX] (CORE_RST_O && rkey_flag_q))
    else $error("Bad reset key gave no delayed reset");
  sleep_pcsp_a: assert property ((timeout && SLEEP_I && !fire)
    |=> PC_SP_RST_O && !CORE_RST_O && TIMEOUT_FLAG_O)
    else $error("Sleep time-out reset more than PC and SP");
  clr_count_a: assert property (WDT_CLEAR_I |=> cnt_q == 18'h00000)
    else $error("Clear instruction left the counter running");
  halt_flags_a: assert property ((HALT_I && !timeout)
    |=> POWER_DOWN_FLAG_O && !TIMEOUT_FLAG_O && cnt_q == 18'h00000)
    else $error("Halt did not set up sleep flags");
  flag_high_a: assert property ((ap_valid && !HWRITE_I && HADDR_I[7:0] == `OFS_RST_FLAGS)
    |=> HRDATA_O[31:4] == 28'h0000000)
    else $error("Unused flag bits read nonzero");

  to_full_c: cover property (timeout && !SLEEP_I);
  to_sleep_c: cover property (timeout && SLEEP_I);
  key_fire_c: cover property (fire && src_wdt_q);
  rkey_fire_c: cover property (fire && src_rst_q);
endmodule

//--- sim/core_model.sv
// CPU core model issuing watchdog clear and halt instructions
`timescale 1ns/1ps
module core_model (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic clr_req_i,
  input  wire logic halt_req_i,
  input  wire logic pc_sp_rst_i,
  output logic      clr_o,
  output logic      halt_o,
  output logic      sleep_o
);
  // One-cycle instruction pulses; a lone clear instruction is enough to clear the counter
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clr_o  <= 1'b0;
      halt_o <= 1'b0;
    end else begin
      clr_o  <= clr_req_i;
      halt_o <= halt_req_i;
    end
  end
  // Halt sends the core to sleep; only a PC and SP reset brings it back
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sleep_o <= 1'b0;
    end else if (halt_o) begin
      sleep_o <= 1'b1;
    end else if (pc_sp_rst_i) begin
      sleep_o <= 1'b0;
    end
  end
endmodule

//--- sim/test_watchdog_and_reset_guard.sv
// Self-checking bench for the watchdog and reset key guard
`timescale 1ns/1ps
`include "wdt_guard_regs.svh"
module test_watchdog_and_reset_guard;
  logic        clk, rstn, hsel, hwrite, hready, hresp, osc;
  logic        clr_req, halt_req, clr, halt, sleep;
  logic        core_rst, pc_sp_rst, to_flag, pd_flag;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd, seed, v;
  int          mismatches, samples_checked, core_n, pcsp_n, c0, n;
  int          tbl[8] = '{8, 10, 12, 14, 15, 16, 17, 18};

  wdt_guard dut (.CLK_I(clk), .RSTN_I(rstn), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
    .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
    .SLOW_OSC_I(osc), .WDT_CLEAR_I(clr), .HALT_I(halt), .SLEEP_I(sleep),
    .CORE_RST_O(core_rst), .PC_SP_RST_O(pc_sp_rst), .TIMEOUT_FLAG_O(to_flag),
    .POWER_DOWN_FLAG_O(pd_flag));
  core_model core (.clk_i(clk), .rst_n_i(rstn), .clr_req_i(clr_req), .halt_req_i(halt_req),
    .pc_sp_rst_i(pc_sp_rst), .clr_o(clr), .halt_o(halt), .sleep_o(sleep));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Reset pulse counters, sampled mid-cycle to avoid edge races
  always @(negedge clk) begin
    if (core_rst === 1'b1) core_n++;
    if (pc_sp_rst === 1'b1) pcsp_n++;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Single AHB transfer; waits on hready, no wait-state count assumed
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
    check({31'h0, hresp}, 32'h0);
  endtask
  // Slow clock edges, four system cycles apiece, then sync settle
  task automatic ticks(input int k);
    repeat (k) begin
      osc <= 1'b1;
      repeat (2) @(posedge clk);
      osc <= 1'b0;
      repeat (2) @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask
  task automatic instr(input logic h);
    if (h) halt_req <= 1'b1;
    else clr_req <= 1'b1;
    @(posedge clk);
    clr_req  <= 1'b0;
    halt_req <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic give_verdict();
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    #800000;
    mismatches++;
    give_verdict();
  end

  initial begin
    {rstn, hsel, hwrite, osc, clr_req, halt_req} = '0;
    {haddr, hwdata, htrans} = '0;
    {mismatches, samples_checked, core_n, pcsp_n} = '0;
    seed = 32'hc82ec77d;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    core_n = 0;
    pcsp_n = 0;
    // Power-on register values, unmapped place reads zero
    rdc(`OFS_WDT_CTRL, 32'h53);
    rdc(`OFS_RST_KEY, 32'h55);
    rdc(`OFS_RST_FLAGS, 32'h0);
    rdc(8'h40, 32'h0);
    // Random count, then single clear, then halt
    n = 20 + int'(xs() % 200);
    ticks(n);
    rdc(`OFS_COUNT, n);
    instr(1'b0);
    rdc(`OFS_COUNT, 32'h0);
    instr(1'b1);
    rdc(`OFS_STATUS, 32'h2);
    // Sleeping time-out: only PC and SP reset, registers kept
    bus(1'b1, `OFS_WDT_CTRL, 32'ha8);
    c0 = core_n;
    ticks(255);
    check(pcsp_n, 0);
    ticks(1);
    check(pcsp_n, 1);
    check(core_n, c0);
    rdc(`OFS_STATUS, 32'h3);
    rdc(`OFS_WDT_CTRL, 32'ha8);
    instr(1'b1);
    check(to_flag, 1'b0);
    // Sleeping core only wakes on a PC and SP reset, so let a time-out give one
    ticks(256);
    check(pcsp_n, 2);
    instr(1'b0);
    // Awake time-outs for the three shortest periods
    for (int c = 0; c < 3; c++) begin
      bus(1'b1, `OFS_WDT_CTRL, {24'h0, 5'h0a, c[2:0]});
      c0 = core_n;
      ticks((1 << tbl[c]) - 1);
      check(core_n, c0);
      ticks(1);
      check(core_n, c0 + 1);
      check(to_flag, 1'b1);
      rdc(`OFS_WDT_CTRL, 32'h53);
    end
    // Alternate keys stay quiet
    bus(1'b1, `OFS_WDT_CTRL, 32'hab);
    bus(1'b1, `OFS_RST_KEY, 32'haa);
    c0 = core_n;
    repeat (150) @(posedge clk);
    check(core_n, c0);
    // Bad keys, repaired at once, still reset after the delay
    for (int k = 0; k < 4; k++) begin
      do v = xs() & 32'hff;
      while (k[0] ? (v == 32'h55 || v == 32'haa) : (v[7:3] == 5'h0a || v[7:3] == 5'h15));
      ticks(10);
      c0 = core_n;
      bus(1'b1, k[0] ? `OFS_RST_KEY : `OFS_WDT_CTRL, v);
      if (!k[0]) rdc(`OFS_COUNT, 32'h0);
      bus(1'b1, k[0] ? `OFS_RST_KEY : `OFS_WDT_CTRL, k[0] ? 32'haa : 32'ha8);
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (core_rst !== 1'b1 && n < 400);
      check(n > 80 && n < 110, 1'b1);
      rdc(`OFS_RST_FLAGS, k[0] ? 32'h8 : 32'h1);
      rdc(k[0] ? `OFS_RST_KEY : `OFS_WDT_CTRL, k[0] ? 32'h55 : 32'h53);
      bus(1'b1, `OFS_RST_FLAGS, 32'hff);
      rdc(`OFS_RST_FLAGS, k[0] ? 32'h8 : 32'h1);
      bus(1'b1, `OFS_RST_FLAGS, 32'h0);
      rdc(`OFS_RST_FLAGS, 32'h0);
    end
    give_verdict();
  end
endmodule
